// >>> rtl/pec_map.vh
// register map, page layout and counter parameters of the event counter log
// assumes a 32-bit classic wishbone slave and a 512-byte little-endian page
`ifndef PEC_MAP_VH
`define PEC_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define PEC_REG_CTRL 8'h00
`define PEC_REG_STATUS 8'h04
`define PEC_REG_DATA 8'h08
`define PEC_REG_CNT_BASE 8'h40
`define PEC_REG_CNT_LAST 8'h68

// ==========================================================
// control and status fields
`define PEC_CTRL_SNAP 0
`define PEC_CTRL_RDCLR 1
`define PEC_CTRL_CLR 2
`define PEC_STAT_PTR_MSB 6
`define PEC_STAT_READY 8
`define PEC_STAT_SAT 9

// ==========================================================
// counters
`define PEC_NUM_CNT 11
`define PEC_CNT_W 16
`define PEC_CNT_MAX 16'hFFFF
`define PEC_SIZE_CODE 3'h3
`define PEC_ID_END 16'h0000

// ==========================================================
// page layout in dwords
`define PEC_PTR_W 7
`define PEC_DW_FIRST_ENTRY 7'h01
`define PEC_DW_LAST_ENTRY 7'h16
`define PEC_DW_END_MARK 7'h17
`define PEC_DW_CKSUM 7'h7F

`endif

// >>> rtl/pec_sat_cnt.v
// one saturating event counter with clear
// assumes clear and event are single-cycle strobes on the core clock
`timescale 1ns/10ps
`include "pec_map.vh"

module pec_sat_cnt (
   input wire clk,
   input wire rst,
   input wire clr,
   input wire inc,
   output reg [`PEC_CNT_W-1:0] cnt_r,
   output wire full
);

   assign full = (cnt_r == `PEC_CNT_MAX);

   // ==========================================================
   // count, hold at maximum
   always @(posedge clk) begin
      if (rst) begin
         cnt_r <= {`PEC_CNT_W{1'b0}};
      end else if (clr) begin
         // event in the clearing cycle is kept
         cnt_r <= inc ? {{(`PEC_CNT_W-1){1'b0}}, 1'b1} : {`PEC_CNT_W{1'b0}};
      end else if (inc && !full) begin // see RULE18
         cnt_r <= cnt_r + {{(`PEC_CNT_W-1){1'b0}}, 1'b1};
      end
   end

endmodule // pec_sat_cnt

// >>> rtl/pec_event_log.v
// event counters and the 512-byte log page that reports them
// assumes event strobes from link logic on ref_clk; phy_rdy comes from the phy
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "pec_map.vh"

// Behaviour
// RULE1: each entry is identifier then value
// RULE2: unused slots carry identifier zero
// RULE3: unimplemented optional counters never appear
// RULE4: zero value means no events seen
// RULE5: entry order is free
// RULE6: id bits 14:12 give width
// RULE7: bit 15 marks vendor counters
// RULE8: id 000h ends the list
// RULE9: count commands failed with crc error
// RULE10: count data frames r_err either direction
// RULE11: split data r_err by direction
// RULE12: non-data r_err counts, retries included
// RULE13: count phy ready rising transitions
// RULE14: count reset signatures acknowledged r_ok
// RULE15: host frames r_err crc versus other
// RULE16: single 512-byte page, header dword first
// RULE17: saturated narrow counter one-extends upward
// RULE18: counters saturate, never wrap
// RULE19: last byte makes page sum zero
// RULE20: reserved bytes and bits read zero
// RULE21: host stops parsing at zero id
// RULE22: transmitted is device to host
// RULE23: bist activate clears all counters
// RULE24: read with clear returns then clears
// RULE25: counters survive comreset, not power
// RULE26: bytes after end marker are zero
module pec_event_log (
   input wire ref_clk,
   input wire sys_rst,
   input wire wb_cyc,
   input wire wb_stb,
   input wire wb_we,
   input wire [7:0] wb_adr,
   input wire [3:0] wb_sel,
   input wire [31:0] wb_dat_w,
   output reg [31:0] wb_dat_r,
   output reg wb_ack,
   input wire evt_cmd_icrc,
   input wire evt_tx_data_rerr,
   input wire evt_rx_data_rerr,
   input wire evt_tx_ndata_rerr,
   input wire evt_rx_ndata_rerr,
   input wire evt_sig_rok,
   input wire evt_rx_crc_rerr,
   input wire evt_rx_other_rerr,
   input wire bist_activate,
   input wire phy_rdy,
   output reg page_ready_r
);

   localparam N = `PEC_NUM_CNT;
   localparam W = `PEC_CNT_W;

   // identifiers, index 0 last (rightmost); only implemented counters listed
   localparam [N*12-1:0] ID_LIST = {
      12'h00D, 12'h00B, 12'h00A, 12'h009, 12'h007, 12'h006,
      12'h005, 12'h004, 12'h003, 12'h002, 12'h001
   }; // see RULE3 see RULE5

   // ==========================================================
   // phy ready synchroniser and rising edge
   reg rdy_meta_r;
   reg rdy_sync_r;
   reg rdy_prev_r;
   wire rdy_rise;

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         rdy_meta_r <= 1'b0;
         rdy_sync_r <= 1'b0;
         rdy_prev_r <= 1'b0;
      end else begin
         rdy_meta_r <= phy_rdy;
         rdy_sync_r <= rdy_meta_r;
         rdy_prev_r <= rdy_sync_r;
      end
   end

   assign rdy_rise = rdy_sync_r && !rdy_prev_r; // see RULE13

   // ==========================================================
   // event routing, transmitted = device to host
   wire [N-1:0] evt;

   assign evt[0] = evt_cmd_icrc; // see RULE9
   assign evt[1] = evt_tx_data_rerr | evt_rx_data_rerr; // see RULE10
   assign evt[2] = evt_tx_data_rerr; // see RULE11 see RULE22
   assign evt[3] = evt_rx_data_rerr; // see RULE11 see RULE22
   assign evt[4] = evt_tx_ndata_rerr | evt_rx_ndata_rerr; // see RULE12
   assign evt[5] = evt_tx_ndata_rerr; // see RULE12
   assign evt[6] = evt_rx_ndata_rerr; // see RULE12
   assign evt[7] = rdy_rise;
   assign evt[8] = evt_sig_rok; // see RULE14
   assign evt[9] = evt_rx_crc_rerr; // see RULE15
   assign evt[10] = evt_rx_other_rerr; // see RULE15

   // ==========================================================
   // bus decode
   wire req;
   wire wr;
   wire rd;
   wire hit_ctrl;
   wire hit_stat;
   wire hit_data;
   wire hit_cnt;
   wire [3:0] cnt_sel;
   wire [7:0] cnt_off;

   assign req = wb_cyc && wb_stb && !wb_ack;
   assign wr = req && wb_we;
   assign rd = req && !wb_we;
   assign hit_ctrl = (wb_adr == `PEC_REG_CTRL);
   assign hit_stat = (wb_adr == `PEC_REG_STATUS);
   assign hit_data = (wb_adr == `PEC_REG_DATA);
   assign hit_cnt = (wb_adr >= `PEC_REG_CNT_BASE) && (wb_adr <= `PEC_REG_CNT_LAST) &&
      (wb_adr[1:0] == 2'b00);
   assign cnt_off = wb_adr - `PEC_REG_CNT_BASE;
   assign cnt_sel = cnt_off[5:2];

   wire ctrl_wr;
   wire snap_go;
   wire clr_now;

   assign ctrl_wr = wr && hit_ctrl && wb_sel[0];
   assign snap_go = ctrl_wr && wb_dat_w[`PEC_CTRL_SNAP];
   // clear after capture when read-with-clear asked, or direct clear, or bist
   assign clr_now = bist_activate || // see RULE23
      (snap_go && wb_dat_w[`PEC_CTRL_RDCLR]) || // see RULE24
      (ctrl_wr && wb_dat_w[`PEC_CTRL_CLR]);

   // ==========================================================
   // counters; only sys_rst (power-on) and the clears above reset them
   wire [N*W-1:0] live;
   wire [N-1:0] full;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1) begin : g_cnt
         pec_sat_cnt u_cnt (
            .clk(ref_clk),
            .rst(sys_rst), // see RULE25
            .clr(clr_now),
            .inc(evt[gi]),
            .cnt_r(live[gi*W +: W]),
            .full(full[gi]) // see RULE18
         );
      end
   endgenerate

   // ==========================================================
   // snapshot taken before any clear of the same cycle
   reg [N*W-1:0] snap_r;
   reg [N-1:0] snap_full_r;

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         snap_r <= {(N*W){1'b0}};
         snap_full_r <= {N{1'b0}};
      end else if (snap_go) begin // see RULE24
         snap_r <= live;
         snap_full_r <= full;
      end
   end

   // ==========================================================
   // page entries: id, then 48-bit value one-extended when saturated
   wire [N*32-1:0] dw_lo;
   wire [N*32-1:0] dw_hi;
   wire [7:0] acc [0:N];

   assign acc[0] = 8'h00; // header dword is all zero

   generate
      for (gi = 0; gi < N; gi = gi + 1) begin : g_ent
         wire [15:0] id;
         wire [15:0] val;
         wire [31:0] ext;
         assign id = {1'b0, `PEC_SIZE_CODE, ID_LIST[gi*12 +: 12]}; // see RULE6 see RULE7
         assign val = snap_r[gi*W +: W];
         assign ext = snap_full_r[gi] ? 32'hFFFFFFFF : 32'h00000000; // see RULE17
         assign dw_lo[gi*32 +: 32] = {val, id}; // see RULE1 see RULE4
         assign dw_hi[gi*32 +: 32] = ext;
         assign acc[gi+1] = acc[gi] + id[7:0] + id[15:8] + val[7:0] + val[15:8] +
            ext[7:0] + ext[15:8] + ext[23:16] + ext[31:24];
      end
   endgenerate

   wire [7:0] cksum;

   assign cksum = 8'h00 - acc[N]; // see RULE19

   // ==========================================================
   // page dword at the read pointer
   reg [`PEC_PTR_W-1:0] ptr_r;
   reg [31:0] page_dw;
   wire [`PEC_PTR_W-1:0] ent_dw;
   wire [3:0] ent_idx;

   assign ent_dw = ptr_r - `PEC_DW_FIRST_ENTRY;
   assign ent_idx = ent_dw[4:1];

   always @* begin
      page_dw = 32'h00000000; // see RULE20 see RULE26
      if (ptr_r >= `PEC_DW_FIRST_ENTRY && ptr_r <= `PEC_DW_LAST_ENTRY) begin // see RULE16
         if (ent_dw[0]) begin
            page_dw = dw_hi[ent_idx*32 +: 32];
         end else begin
            page_dw = dw_lo[ent_idx*32 +: 32];
         end
      end else if (ptr_r == `PEC_DW_END_MARK) begin
         page_dw = {16'h0000, `PEC_ID_END}; // see RULE8 see RULE2
      end else if (ptr_r == `PEC_DW_CKSUM) begin
         page_dw = {cksum, 24'h000000}; // see RULE19
      end
   end

   // ==========================================================
   // read pointer: reset by a snapshot, advanced by each data read
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ptr_r <= {`PEC_PTR_W{1'b0}};
         page_ready_r <= 1'b0;
      end else if (snap_go) begin
         ptr_r <= {`PEC_PTR_W{1'b0}};
         page_ready_r <= 1'b1;
      end else if (rd && hit_data) begin
         ptr_r <= ptr_r + {{(`PEC_PTR_W-1){1'b0}}, 1'b1};
         if (ptr_r == `PEC_DW_CKSUM) begin
            page_ready_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read data and acknowledge, one wait state
   reg [31:0] rdata;

   always @* begin
      rdata = 32'h00000000;
      if (hit_stat) begin
         rdata[`PEC_STAT_PTR_MSB:0] = ptr_r;
         rdata[`PEC_STAT_READY] = page_ready_r;
         rdata[`PEC_STAT_SAT] = |full;
      end else if (hit_data) begin
         rdata = page_dw;
      end else if (hit_cnt) begin
         rdata = {16'h0000, live[cnt_sel*W +: W]};
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack <= req;
         if (rd) begin
            wb_dat_r <= rdata;
         end
      end
   end

endmodule // pec_event_log

// >>> testbench/pec_event_log_checker.sv
// bus and page-ready checks on the event log ports
// assumes bound to pec_event_log with one clock ref_clk
`timescale 1ns/10ps
module pec_event_log_checker (
   input wire ref_clk,
   input wire sys_rst,
   input wire wb_cyc,
   input wire wb_stb,
   input wire wb_we,
   input wire [7:0] wb_adr,
   input wire [3:0] wb_sel,
   input wire [31:0] wb_dat_w,
   input wire [31:0] wb_dat_r,
   input wire wb_ack,
   input wire page_ready_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // handshake
   property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_lat; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_cause; wb_ack |-> $past(wb_cyc && wb_stb); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_hold; $changed(wb_dat_r) |-> wb_ack; endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
   // ==========================================
   // page ready and zero fields
   property p_rdy_set;
      wb_ack && $past(wb_we && wb_sel[0] && wb_adr == 8'h00 && wb_dat_w[0]) |-> page_ready_r;
   endproperty
   a_rdy_set: assert property (p_rdy_set) else $error("snapshot not ready");
   property p_rdy_fall; $fell(page_ready_r) |-> wb_ack && $past(wb_adr == 8'h08); endproperty
   a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell without read");
   property p_stat_zero;
      wb_ack && $past(!wb_we && wb_adr == 8'h04) |-> wb_dat_r[31:10] == 0 && !wb_dat_r[7];
   endproperty
   a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");
   property p_unmap; wb_ack && $past(!wb_we && wb_adr == 8'h10) |-> wb_dat_r == 0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // pec_event_log_checker

bind pec_event_log pec_event_log_checker u_chk (.ref_clk, .sys_rst, .wb_cyc, .wb_stb, .wb_we,
   .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .page_ready_r);

// >>> testbench/pec_host.sv
// host model: classic wishbone reads and writes of the log
// assumes the bench calls xfer and page by hierarchy
`timescale 1ns/10ps
module pec_host (
   input wire ref_clk,
   input wire wb_ack,
   input wire [31:0] wb_dat_r,
   output reg wb_cyc,
   output reg wb_stb,
   output reg wb_we,
   output reg [7:0] wb_adr,
   output reg [3:0] wb_sel,
   output reg [31:0] wb_dat_w
);
   initial {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
   // ==========================================
   // one cycle, held until ack
   task xfer(input w, input [7:0] a, input [31:0] dw, output [31:0] d);
      begin
         @(posedge ref_clk);
         {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
         wb_adr <= a;
         wb_sel <= 4'hF;
         wb_dat_w <= dw;
         @(posedge ref_clk);
         while (wb_ack !== 1'b1) @(posedge ref_clk);
         d = wb_dat_r;
         {wb_cyc, wb_stb} <= 2'b00;
         // released lines toggle
         wb_adr <= ~a;
         wb_dat_w <= ~dw;
      end
   endtask
   // ==========================================
   // whole page, entries parsed up to zero id
   task page(output logic [31:0] pg [128], output integer n);
      reg [31:0] d;
      reg stop;
      integer k;
      begin
         stop = 0;
         n = 0;
         for (k = 0; k < 128; k++) begin
            xfer(1'b0, 8'h08, 32'h0, d);
            pg[k] = d;
            if (k % 2 == 1 && !stop) begin
               if (d[15:0] == 16'h0000) stop = 1;
               else n++;
            end
         end
      end
   endtask
endmodule // pec_host

// >>> testbench/pec_event_log_bench.sv
// self-checking bench of the event log
// assumes pec_host drives the bus, bench drives events
`timescale 1ns/10ps
module pec_event_log_bench;
   reg ref_clk = 0;
   reg sys_rst = 1;
   reg [7:0] ev = 0;
   reg bist = 0;
   reg phy = 0;
   wire wb_cyc, wb_stb, wb_we, wb_ack, rdy;
   wire [7:0] wb_adr;
   wire [3:0] wb_sel;
   wire [31:0] wb_dat_w, wb_dat_r;
   integer fail_count = 0;
   integer cmp_count = 0;
   reg [31:0] pg [128];
   reg [15:0] code [11] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 13};
   reg [15:0] exp [11] = '{1, 5, 2, 3, 9, 4, 5, 2, 16'hFFFF, 7, 8};
   always #10 ref_clk = ~ref_clk;
   pec_event_log dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
      .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .evt_cmd_icrc(ev[0]), .evt_tx_data_rerr(ev[1]),
      .evt_rx_data_rerr(ev[2]), .evt_tx_ndata_rerr(ev[3]), .evt_rx_ndata_rerr(ev[4]),
      .evt_sig_rok(ev[5]), .evt_rx_crc_rerr(ev[6]), .evt_rx_other_rerr(ev[7]),
      .bist_activate(bist), .phy_rdy(phy), .page_ready_r(rdy));
   pec_host h (.ref_clk(ref_clk), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w));
   // ==========================================
   // compare and verdict
   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         cmp_count++;
         if (s !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", n, e, s);
         end
      end
   endtask
   task close_out;
      begin
         if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // ==========================================
   // events, saturation, read-and-clear page
   task t_page;
      reg [31:0] d;
      reg [7:0] sum;
      integer k, j, n;
      begin
         for (k = 0; k < 8; k++)
            for (j = 0; j <= k; j++) begin
               @(posedge ref_clk) ev <= 8'h01 << k;
               @(posedge ref_clk) ev <= 8'h00;
            end
         repeat (2) begin
            repeat (5) @(posedge ref_clk) phy <= 1'b1;
            repeat (5) @(posedge ref_clk) phy <= 1'b0;
         end
         @(posedge ref_clk) ev <= 8'h20;
         repeat (65540) @(posedge ref_clk);
         ev <= 8'h00;
         h.xfer(1'b0, 8'h04, 32'h0, d);
         chk("status sat", d, 32'h200);
         h.xfer(1'b1, 8'h00, 32'h3, d);
         chk("ready", rdy, 1);
         h.page(pg, n);
         chk("ready end", rdy, 0);
         chk("entries", n, 11);
         chk("header", pg[0], 0);
         for (k = 0; k < 11; k++) begin
            chk("id", pg[1 + 2 * k][15:0], 16'h3000 | code[k]);
            chk("value", pg[1 + 2 * k][31:16], exp[k]);
            chk("upper", pg[2 + 2 * k], exp[k] == 16'hFFFF ? 32'hFFFFFFFF : 0);
         end
         for (k = 23; k < 127; k++) chk("tail", pg[k], 0);
         chk("spare", pg[127][23:0], 0);
         sum = 0;
         for (k = 0; k < 128; k++) sum = sum + pg[k][7:0] + pg[k][15:8] + pg[k][23:16] + pg[k][31:24];
         chk("sum", sum, 0);
         for (k = 0; k < 11; k++) begin
            h.xfer(1'b0, 8'h40 + 4 * k, 32'h0, d);
            chk("cleared", d, 0);
         end
      end
   endtask
   // ==========================================
   // status, plain snapshot, direct clear
   task t_ctrl;
      reg [31:0] d;
      begin
         h.xfer(1'b0, 8'h04, 32'h0, d);
         chk("status idle", d, 0);
         @(posedge ref_clk) ev <= 8'h80;
         @(posedge ref_clk) ev <= 8'h00;
         h.xfer(1'b1, 8'h00, 32'h1, d);
         h.xfer(1'b0, 8'h08, 32'h0, d);
         chk("header2", d, 0);
         h.xfer(1'b0, 8'h04, 32'h0, d);
         chk("status ptr", d, 32'h101);
         h.xfer(1'b0, 8'h68, 32'h0, d);
         chk("kept", d, 1);
         h.xfer(1'b1, 8'h00, 32'h4, d);
         h.xfer(1'b0, 8'h68, 32'h0, d);
         chk("clear", d, 0);
      end
   endtask
   // ==========================================
   // bist clear and unmapped place
   task t_bist;
      reg [31:0] d;
      begin
         @(posedge ref_clk) ev <= 8'h01;
         @(posedge ref_clk) ev <= 8'h00;
         h.xfer(1'b0, 8'h40, 32'h0, d);
         chk("icrc", d, 1);
         @(posedge ref_clk) bist <= 1'b1;
         @(posedge ref_clk) bist <= 1'b0;
         h.xfer(1'b0, 8'h40, 32'h0, d);
         chk("bist", d, 0);
         h.xfer(1'b0, 8'h10, 32'h0, d);
         chk("unmapped", d, 0);
      end
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_page;
      t_ctrl;
      t_bist;
      close_out;
   end
   initial begin
      #2000000;
      fail_count++;
      close_out;
   end
endmodule // pec_event_log_bench
